/* hdl/adcc_pkg.sv */
// Package for the converter control block: register map, fields, codes.
// Assumes a 32-bit APB bus with byte addresses as printed.
package adcc_pkg;
    localparam logic [31:0] STATUS_ADDR   = 32'h4004_8000;
    localparam logic [31:0] SELECT_ADDR   = 32'h4004_8004;
    localparam logic [31:0] CONTROL_ADDR  = 32'h4004_8008;
    localparam logic [31:0] RESULT_ADDR   = 32'h4004_8048;
    localparam logic [31:0] IRQ_STAT_ADDR = 32'h4004_804c;
    localparam logic [31:0] IRQ_MASK_ADDR = 32'h4004_8050;

    localparam int RES_MSB      = 9;
    localparam int RES_LSB      = 7;
    localparam int PWR_BIT      = 2;
    localparam int TRIG_BIT     = 1;
    localparam int CHAN_MSB     = 5;
    localparam int CHAN_LSB     = 4;
    localparam int ACT_MSB      = 6;
    localparam int ACT_LSB      = 4;
    localparam int RESULT_W     = 10;

    localparam logic [9:0] SELECT_RESET  = 10'h004;
    localparam logic [9:0] CONTROL_RESET = 10'h000;
    localparam logic [9:0] RESULT_RESET  = 10'h000;

    localparam logic [2:0] ACT_STOPPED = 3'h0;
    localparam logic [2:0] ACT_RISE    = 3'h1;
    localparam logic [2:0] ACT_SAMPLE  = 3'h2;
    localparam logic [2:0] ACT_CONVERT = 3'h3;
    localparam logic [2:0] ACT_READY   = 3'h4;

    // Input settling delay before sampling, in ns
    localparam int RISE_NS      = 400;
    localparam int CLK_NS       = 40;
    localparam int RISE_CYC_RAW = (RISE_NS + CLK_NS - 1) / CLK_NS;
    localparam int RISE_CYC     = (RISE_CYC_RAW < 1) ? 1 : RISE_CYC_RAW;

    typedef enum logic [2:0] {
        ADCC_IDLE,
        ADCC_RISE,
        ADCC_SAMPLE,
        ADCC_CONVERT,
        ADCC_READY
    } adcc_state_t;
endpackage

/* hdl/adcc_top.sv */
// Control and result logic of a three-channel successive-approximation converter.
// Assumes an APB master on clk, an analog comparator and trial DAC outside,
// and a slow sampling clock arriving as an ordinary pin.
// Notes on behaviour
// - Resolution field sets ten down to three bits
// - Result bits stay left aligned, unshifted
// - Fewer bits means fewer converter cycles
// - Power bit zero holds power down
// - Trigger one starts conversion on selection
// - Trigger clears itself once conversion starts
// - Reserved bits unspecified; software writes zero
// - Result register holds latest completed conversion
// - Completion raises interrupt; software waits
// - Conversion takes N plus one sample cycles
// - Activity field reports converter phase
// - Channel field selects one of three inputs
//
// The APB slave port was decided locally.
`timescale 1ns/1ns
`default_nettype none
module adcc_top #(
    parameter int RISE_CYCLES = adcc_pkg::RISE_CYC
) (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sample_clk_pin,
    input  wire logic        comparator_pin,
    output logic             analog_power_down,
    output logic             analog_reset,
    output logic [2:0]       analog_input_enable,
    output logic             sample_hold,
    output logic [9:0]       trial_code,
    output logic             irq
);
    logic [9:0]  select_reg;
    logic [9:0]  control_reg;
    logic [9:0]  result_reg;
    logic [9:0]  sar_reg;
    logic [3:0]  bit_reg;
    logic [3:0]  lsb_reg;
    logic [7:0]  rise_cnt_reg;
    logic        irq_stat_reg;
    logic        irq_mask_reg;
    logic        pwr_prev_reg;
    logic [1:0]  sync1_reg;
    logic [1:0]  sync2_reg;
    logic [1:0]  sync3_reg;
    logic [1:0]  filt_reg;
    logic        samp_prev_reg;
    adcc_pkg::adcc_state_t state_reg;
    logic [2:0]  activity;
    logic        wr_en;
    logic        rd_en;
    logic        hit;
    logic        samp_tick;
    logic        conv_start;
    logic        conv_done;
    logic        trig_req;
    logic        pwr_on;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic [9:0]  trial_reg;
    logic [9:0]  trial_next;

    // Rise counter is eight bits; the result width is fixed by the package
    if (RISE_CYCLES < 1 || RISE_CYCLES > 256) begin : g_bad_rise
        $error("RISE_CYCLES must lie in 1 to 256");
    end
    if (adcc_pkg::RESULT_W != 10) begin : g_bad_width
        $error("RESULT_W must be 10");
    end

    assign wr_en = psel & penable & pwrite;
    // Read data captured in the setup cycle, so prdata comes from a flop
    assign rd_en = psel & ~penable & ~pwrite;
    assign pready = 1'b1;
    assign hit = (paddr == adcc_pkg::STATUS_ADDR) | (paddr == adcc_pkg::SELECT_ADDR)
               | (paddr == adcc_pkg::CONTROL_ADDR) | (paddr == adcc_pkg::RESULT_ADDR)
               | (paddr == adcc_pkg::IRQ_STAT_ADDR) | (paddr == adcc_pkg::IRQ_MASK_ADDR);
    assign pslverr = psel & penable & ~hit;

    // Pin synchronisers, three stages each
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync1_reg <= 2'h0;
            sync2_reg <= 2'h0;
            sync3_reg <= 2'h0;
        end else begin
            sync1_reg <= {comparator_pin, sample_clk_pin};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // Level counts once stages two and three agree; rejects one-flop glitches
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            filt_reg <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (sync2_reg[i] == sync3_reg[i]) begin
                    filt_reg[i] <= sync3_reg[i];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            samp_prev_reg <= 1'b0;
        end else begin
            samp_prev_reg <= filt_reg[0];
        end
    end

    // Rising edge of the filtered sample clock
    assign samp_tick = filt_reg[0] & ~samp_prev_reg;
    assign pwr_on = control_reg[adcc_pkg::PWR_BIT];
    assign trig_req = control_reg[adcc_pkg::TRIG_BIT];
    assign conv_start = (state_reg == adcc_pkg::ADCC_IDLE) & trig_req & pwr_on;
    assign conv_done = (state_reg == adcc_pkg::ADCC_READY);

    // Channel select register, all bits stored as written
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            select_reg <= adcc_pkg::SELECT_RESET;
        end else if (wr_en && paddr == adcc_pkg::SELECT_ADDR) begin
            select_reg <= pwdata[9:0];
        end
    end

    // Control register with self-clearing trigger
    // A trigger written while busy waits for the stopped state
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            control_reg <= adcc_pkg::CONTROL_RESET;
        end else if (wr_en && paddr == adcc_pkg::CONTROL_ADDR) begin
            control_reg <= pwdata[9:0];
            control_reg[adcc_pkg::TRIG_BIT] <= pwdata[adcc_pkg::TRIG_BIT]
                                               & pwdata[adcc_pkg::PWR_BIT];
        end else if (conv_start || !pwr_on) begin
            control_reg[adcc_pkg::TRIG_BIT] <= 1'b0;
        end
    end

    // Conversion sequencer
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg    <= adcc_pkg::ADCC_IDLE;
            rise_cnt_reg <= 8'h00;
            bit_reg      <= 4'h0;
            lsb_reg      <= 4'h0;
        end else if (!pwr_on) begin
            state_reg <= adcc_pkg::ADCC_IDLE;
        end else begin
            unique case (state_reg)
                adcc_pkg::ADCC_IDLE: begin
                    if (conv_start) begin
                        state_reg    <= adcc_pkg::ADCC_RISE;
                        rise_cnt_reg <= 8'(RISE_CYCLES - 1);
                        lsb_reg      <= {1'b0, control_reg[adcc_pkg::RES_MSB:adcc_pkg::RES_LSB]};
                    end
                end
                adcc_pkg::ADCC_RISE: begin
                    if (rise_cnt_reg == 8'h00) begin
                        state_reg <= adcc_pkg::ADCC_SAMPLE;
                    end else begin
                        rise_cnt_reg <= rise_cnt_reg - 8'h01;
                    end
                end
                adcc_pkg::ADCC_SAMPLE: begin
                    if (samp_tick) begin
                        state_reg <= adcc_pkg::ADCC_CONVERT;
                        bit_reg   <= 4'(adcc_pkg::RESULT_W - 1);
                    end
                end
                adcc_pkg::ADCC_CONVERT: begin
                    if (samp_tick) begin
                        if (bit_reg == lsb_reg) begin
                            state_reg <= adcc_pkg::ADCC_READY;
                        end else begin
                            bit_reg <= bit_reg - 4'h1;
                        end
                    end
                end
                adcc_pkg::ADCC_READY: begin
                    state_reg <= adcc_pkg::ADCC_IDLE;
                end
                // Unused codes fall back to stopped
                default: begin
                    state_reg <= adcc_pkg::ADCC_IDLE;
                end
            endcase
        end
    end

    // Successive approximation register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sar_reg <= 10'h000;
        end else if (state_reg == adcc_pkg::ADCC_SAMPLE) begin
            sar_reg <= 10'h000;
        end else if (state_reg == adcc_pkg::ADCC_CONVERT && samp_tick) begin
            sar_reg[bit_reg] <= filt_reg[1];
        end
    end

    // Trial code: decided bits plus the bit under test
    always_comb begin
        trial_next = sar_reg;
        if (state_reg == adcc_pkg::ADCC_CONVERT) begin
            trial_next[bit_reg] = 1'b1;
        end
    end

    // Registered so the trial DAC never sees decode glitches
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            trial_reg <= 10'h000;
        end else begin
            trial_reg <= trial_next;
        end
    end

    assign trial_code = trial_reg;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            result_reg <= adcc_pkg::RESULT_RESET;
        end else if (conv_done) begin
            result_reg <= sar_reg;
        end
    end

    // Completion wins over a clear in the same cycle
    // sticky done flag
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_stat_reg <= 1'b0;
        end else if (conv_done) begin
            irq_stat_reg <= 1'b1;
        end else if (wr_en && paddr == adcc_pkg::IRQ_STAT_ADDR && pwdata[0]) begin
            irq_stat_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_mask_reg <= 1'b0;
        end else if (wr_en && paddr == adcc_pkg::IRQ_MASK_ADDR) begin
            irq_mask_reg <= pwdata[0];
        end
    end

    assign irq = irq_stat_reg & irq_mask_reg;

    // Internal reset pulse on each power-up
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pwr_prev_reg <= 1'b0;
            analog_reset <= 1'b0;
        end else begin
            pwr_prev_reg <= pwr_on;
            analog_reset <= pwr_on & ~pwr_prev_reg;
        end
    end

    assign analog_power_down = ~pwr_on;
    assign sample_hold = (state_reg == adcc_pkg::ADCC_SAMPLE) & pwr_on;

    always_comb begin
        analog_input_enable = 3'h0;
        unique case (select_reg[adcc_pkg::CHAN_MSB:adcc_pkg::CHAN_LSB])
            2'h0: analog_input_enable = 3'h1;
            2'h1: analog_input_enable = 3'h2;
            2'h2: analog_input_enable = 3'h4;
            2'h3: analog_input_enable = 3'h0;
        endcase
    end

    always_comb begin
        activity = adcc_pkg::ACT_STOPPED;
        unique case (state_reg)
            adcc_pkg::ADCC_IDLE:    activity = adcc_pkg::ACT_STOPPED;
            adcc_pkg::ADCC_RISE:    activity = adcc_pkg::ACT_RISE;
            adcc_pkg::ADCC_SAMPLE:  activity = adcc_pkg::ACT_SAMPLE;
            adcc_pkg::ADCC_CONVERT: activity = adcc_pkg::ACT_CONVERT;
            adcc_pkg::ADCC_READY:   activity = adcc_pkg::ACT_READY;
            default:                activity = adcc_pkg::ACT_STOPPED;
        endcase
    end

    always_comb begin
        prdata_next = 32'h0000_0000;
        if (rd_en) begin
            unique case (paddr)
                adcc_pkg::STATUS_ADDR:   prdata_next[adcc_pkg::ACT_MSB:adcc_pkg::ACT_LSB]
                                             = activity;
                adcc_pkg::SELECT_ADDR:   prdata_next[9:0] = select_reg;
                adcc_pkg::CONTROL_ADDR:  prdata_next[9:0] = control_reg;
                adcc_pkg::RESULT_ADDR:   prdata_next[9:0] = result_reg;
                adcc_pkg::IRQ_STAT_ADDR: prdata_next[0] = irq_stat_reg;
                adcc_pkg::IRQ_MASK_ADDR: prdata_next[0] = irq_mask_reg;
                default:                 prdata_next = 32'h0000_0000;
            endcase
        end
    end

    // Zero outside the access phase of a read
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prdata_reg <= 32'h0000_0000;
        end else begin
            prdata_reg <= prdata_next;
        end
    end

    assign prdata = prdata_reg;
endmodule
`default_nettype wire

/* verif/adcc_checker.sv */
// Port checker for the converter control block.
// Assumes one clock, nrst active low, attached by bind below.
`timescale 1ns/1ns
`default_nettype none
module adcc_checker (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        analog_power_down,
    input wire logic        analog_reset,
    input wire logic [2:0]  analog_input_enable,
    input wire logic        sample_hold
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    wire logic acc = psel && penable;
    wire logic wr_ctl = acc && pwrite && paddr == adcc_pkg::CONTROL_ADDR;
    wire logic wr_sel = acc && pwrite && paddr == adcc_pkg::SELECT_ADDR;
    chk_pwr_follow: assert property (
        wr_ctl |=> analog_power_down == !$past(pwdata[2]))
        else $error("power state wrong");
    chk_rst_pulse: assert property (
        $fell(analog_power_down) |-> ##[0:1] analog_reset)
        else $error("no converter reset");
    chk_rst_width: assert property (
        analog_reset |=> !analog_reset)
        else $error("reset pulse too long");
    chk_hold_power: assert property (
        sample_hold |-> !analog_power_down)
        else $error("sampling while down");
    chk_chan_decode: assert property (
        wr_sel |=> analog_input_enable == ($past(pwdata[5:4]) == 2'h3 ? 3'h0 :
            3'h1 << $past(pwdata[5:4])))
        else $error("channel enable wrong");
    chk_rsvd_zero: assert property (
        acc && !pwrite |-> prdata[31:10] == 22'h0)
        else $error("reserved bits set");
    chk_rise_delay: assert property (
        $rose(sample_hold) |-> !$past(analog_power_down, 10))
        else $error("rise delay short");
    chk_err_zero: assert property (
        pslverr |-> prdata == 32'h0)
        else $error("error read not zero");
endmodule
bind adcc_top adcc_checker u_chk (.clk, .nrst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pslverr, .analog_power_down, .analog_reset,
    .analog_input_enable, .sample_hold);
`default_nettype wire

/* verif/tb.sv */
// Self-checking bench for the converter control block.
// Bench makes the sample clock and a comparator from the input level in vin, 10'h2a5 then 10'h155.
`timescale 1ns/1ns
`default_nettype none
module tb;
    localparam logic [31:0] CTL = adcc_pkg::CONTROL_ADDR;
    localparam logic [31:0] RES = adcc_pkg::RESULT_ADDR;
    localparam logic [31:0] ST = adcc_pkg::STATUS_ADDR;
    localparam logic [31:0] IST = adcc_pkg::IRQ_STAT_ADDR;
    localparam logic [31:0] MSK = adcc_pkg::IRQ_MASK_ADDR;
    // Resolution code beside the expected left-aligned result
    localparam logic [12:0] ROWS [8] = '{13'h02a5, 13'h06a4, 13'h0aa4, 13'h0ea0,
        13'h12a0, 13'h16a0, 13'h1a80, 13'h1e80};
    logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
    logic [31:0] paddr = 0, pwdata = 0, prdata, rd, edges = 0;
    logic pready, pslverr, er, sample_clk_pin = 0, comparator_pin = 0;
    logic analog_power_down, analog_reset, sample_hold, irq;
    logic [2:0] analog_input_enable, ph = 0;
    logic [9:0] trial_code, vin = 10'h2a5;
    logic [12:0] row;
    int failures = 0, check_count = 0;
    adcc_top uut (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .sample_clk_pin, .comparator_pin, .analog_power_down,
        .analog_reset, .analog_input_enable, .sample_hold, .trial_code, .irq);
    initial begin
        forever #20 clk = !clk;
    end
    // Sample clock 16 clks; edges counts pin rises after sampling ends
    always @(posedge clk) begin
        ph <= ph + 3'h1;
        if (ph == 3'h7) sample_clk_pin <= !sample_clk_pin;
        if (sample_hold) edges <= 0;
        else if (ph == 3'h7 && !sample_clk_pin) edges <= edges + 1;
        // Half-step offset keeps the input off every trial level
        comparator_pin <= {vin, 1'b1} > {trial_code, 1'b0};
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic give_verdict;
        if (failures == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #(40 * 20000);
        failures++;
        give_verdict;
    end
    initial begin
        repeat (4) @(posedge clk);
        nrst <= 1;
        apb(0, CTL, 0);
        chk(rd, 0);
        chk(analog_power_down, 1);
        apb(0, RES, 0);
        chk(rd, 0);
        apb(0, 32'h4004_8044, 0);
        chk({er, rd[30:0]}, 32'h8000_0000);
        apb(1, CTL, 32'h2);
        repeat (40) @(posedge clk);
        chk(sample_hold, 0);
        apb(1, 32'h4004_8004, 32'h294);
        @(posedge clk);
        chk(analog_input_enable, 3'h2);
        apb(1, MSK, 1);
        for (int i = 0; i < 8; i++) begin
            row = ROWS[i];
            apb(1, CTL, {22'h0, row[12:10], 7'h06});
            for (int n = 0; n < 2000 && irq !== 1'b1; n++) @(posedge clk);
            chk(irq, 1);
            chk(edges, 10 - row[12:10]);
            apb(0, ST, 0);
            chk(rd[6:4], 0);
            apb(0, RES, 0);
            chk(rd, {22'h0, row[9:0]});
            apb(0, CTL, 0);
            chk(rd, {22'h0, row[12:10], 7'h04});
            apb(1, IST, 1);
            @(posedge clk);
            chk(irq, 0);
        end
        apb(1, MSK, 0);
        vin <= 10'h155;
        apb(1, CTL, 32'h6);
        repeat (20) @(posedge clk);
        apb(0, RES, 0);
        chk(rd, 32'h280);
        for (int n = 0; n < 300 && rd[0] !== 1'b1; n++) apb(0, IST, 0);
        chk(irq, 0);
        apb(1, MSK, 1);
        @(posedge clk);
        chk(irq, 1);
        apb(0, RES, 0);
        chk(rd, 32'h155);
        apb(1, CTL, 0);
        @(posedge clk);
        chk(analog_power_down, 1);
        // Reset in mid conversion
        apb(1, CTL, 32'h6);
        repeat (30) @(posedge clk);
        nrst <= 0;
        @(posedge clk);
        chk(analog_power_down, 1);
        chk(sample_hold, 0);
        chk(irq, 0);
        chk(trial_code, 0);
        nrst <= 1;
        apb(0, ST, 0);
        chk(rd[6:4], 0);
        apb(0, RES, 0);
        chk(rd, 0);
        apb(0, CTL, 0);
        chk(rd, 0);
        give_verdict;
    end
endmodule
`default_nettype wire
